// >>> rtl/flag_bank_pkg.sv
// Constants and carrier types for the peripheral request flag bank.
// Assumes one 100 MHz system clock and a 32-bit APB slave port.
package flag_bank_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS2  = 8'h00;
  localparam logic [7:0] OFS_FLAGS3  = 8'h04;
  localparam logic [7:0] OFS_FLAGS4  = 8'h08;
  localparam logic [7:0] OFS_ENABLE2 = 8'h0C;
  localparam logic [7:0] OFS_ENABLE3 = 8'h10;
  localparam logic [7:0] OFS_ENABLE4 = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_MASK    = 8'h20;

  // Implemented, software-writable and hardware-level bit masks
  localparam logic [7:0] FLAGS2_IMPL = 8'hEF;
  localparam logic [7:0] FLAGS2_WR   = 8'hEF;
  localparam logic [7:0] FLAGS2_LVL  = 8'h00;
  localparam logic [7:0] FLAGS3_IMPL = 8'hFF;
  localparam logic [7:0] FLAGS3_WR   = 8'hFF;
  localparam logic [7:0] FLAGS3_LVL  = 8'h00;
  localparam logic [7:0] FLAGS4_IMPL = 8'hFF;
  localparam logic [7:0] FLAGS4_WR   = 8'hCF;
  localparam logic [7:0] FLAGS4_LVL  = 8'h30;
  localparam logic [7:0] ENABLE2_IMPL = 8'hEF;

  // Bit positions
  localparam int unsigned CTRL_PERIPHERAL_IRQ_ENABLE_BIT   = 0;
  localparam int unsigned ST_FLAG_SET_BIT = 0;
  localparam int unsigned ST_REQ_RISE_BIT = 1;
  localparam int unsigned ST_SET_WINS_BIT = 2;
  localparam int unsigned ST_W            = 3;

  // Values after reset
  localparam logic [7:0]      FLAGS_RST  = 8'h00;
  localparam logic [7:0]      ENABLE_RST = 8'h00;
  localparam logic            PERIPHERAL_IRQ_ENABLE_RST   = 1'b0;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST   = 3'h0;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  // All three request bytes together
  typedef struct packed {
    logic [7:0] f4;
    logic [7:0] f3;
    logic [7:0] f2;
  } flag_bus_t;

endpackage

// >>> rtl/request_flag_reg.sv
// One 8-bit request flag register with hardware set and software write.
// Assumes set inputs are synchronous single-cycle pulses or levels.
`timescale 1ns/1ps
`default_nettype none
module request_flag_reg
  import flag_bank_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK  = 8'hFF,
  parameter logic [7:0] WRITE_MASK = 8'hFF,
  parameter logic [7:0] LEVEL_MASK = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [7:0] set_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] flags_o,
  output logic      [7:0] newly_set_o,
  output logic            set_wins_o
);

  // Elaboration check; a level bit cannot also take software writes
  if ((LEVEL_MASK & WRITE_MASK) != 8'h00) begin : g_check_level
    $error("level bits cannot be software writable");
  end

  typedef struct packed {
    logic [7:0] flags;
  } reg_state_t;

  reg_state_t q;
  reg_state_t d;
  logic [7:0] base;

  // Write first, then hardware set on top so a same-cycle event survives
  always_comb begin
    d    = q;
    base = q.flags;
    if (wr_i) begin
      base = (wdata_i & WRITE_MASK) | (q.flags & ~WRITE_MASK); // R12
    end
    d.flags = ((base | set_i) & ~LEVEL_MASK) & IMPL_MASK; // R01 R05
    d.flags = d.flags | (set_i & LEVEL_MASK & IMPL_MASK); // R07
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.flags <= FLAGS_RST; // R09
    end else if (en_i) begin
      q <= d;
    end
  end

  assign flags_o     = q.flags; // R03
  assign newly_set_o = en_i ? (d.flags & ~q.flags & set_i) : 8'h00;
  // Set beat a software clear in this cycle
  assign set_wins_o  = en_i & wr_i & (|(set_i & WRITE_MASK & ~wdata_i & IMPL_MASK));

endmodule
`default_nettype wire

// >>> rtl/periph_request_merge.sv
// Merges flags and enables into the registered peripheral request.
// Assumes flags and enables come from flops of the same clock.
`timescale 1ns/1ps
`default_nettype none
module periph_request_merge
  import flag_bank_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      en_i,
  input  wire flag_bus_t flags_i,
  input  wire flag_bus_t enables_i,
  input  wire logic      peripheral_irq_enable_i,
  output logic           req_o
);

  typedef struct packed {
    logic req;
  } merge_state_t;

  merge_state_t q;
  merge_state_t d;

  // Registered so the core sees a glitch-free level
  always_comb begin
    d     = q;
    d.req = peripheral_irq_enable_i & (|(flags_i & enables_i)); // R10 R11
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.req <= 1'b0;
    end else if (en_i) begin
      q <= d;
    end
  end

  assign req_o = q.req;

endmodule
`default_nettype wire

// >>> rtl/peripheral_irq_flag_bank.sv
// Peripheral request flag bank with enables, core request and APB access.
// Assumes peripheral events are synchronous to SYS_CLK_I.
//
// What this block does
// R01: Each flag sets on its peripheral event regardless of any enable.
// R02: Software should clear a flag before enabling its interrupt.
// R03: A flag reading one means pending, zero means not pending.
// R04: Register two holds osc fail, gates, collision, timer matches, capcmp2.
// R05: Register two bit four is unimplemented, ignores writes, reads zero.
// R06: Register three holds capcmp6 to 3 and four timer events.
// R07: Register four bits five and four are read-only UART2 flags.
// R08: Register four other bits are capcmp10,9,8,7 and serial2 flags, writable.
// R09: All flags reset to zero on every reset.
// R10: No request reaches the core unless peripheral enable is set.
// R11: Core request is OR over all flag AND enable pairs.
// R12: Software write overwrites a flag unless a same-cycle set wins.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_bank
  import flag_bank_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CLK_EN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Peripheral events
  input  wire logic        OSC_FAIL_I,
  input  wire logic        TIMER5_GATE_I,
  input  wire logic        TIMER3_GATE_I,
  input  wire logic        SERIAL1_COLLISION_I,
  input  wire logic        TIMER10_MATCH_I,
  input  wire logic        TIMER8_MATCH_I,
  input  wire logic [9:2]  CAPCMP_I,
  input  wire logic        TIMER6_MATCH_I,
  input  wire logic        TIMER5_OVERFLOW_I,
  input  wire logic        TIMER4_MATCH_I,
  input  wire logic        TIMER3_OVERFLOW_I,
  input  wire logic        CAPCMP10_I,
  input  wire logic        UART2_RECEIVE_I,
  input  wire logic        UART2_TRANSMIT_I,
  input  wire logic        SERIAL2_COLLISION_I,
  input  wire logic        SERIAL2_EVENT_I,
  // Core and system interrupt
  output logic             PERIPH_IRQ_REQ_O,
  output logic             IRQ_O
);

  // Whole state of the top in one record
  typedef struct packed {
    logic [7:0]      enable2;
    logic [7:0]      enable3;
    logic [7:0]      enable4;
    logic            peripheral_irq_enable;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0]     prdata;
    logic            pslverr;
    logic            req_prev;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  // Bus view, event routing and flag bank wiring
  apb_req_t   apb;
  flag_bus_t  set_bus;
  flag_bus_t  flags;
  flag_bus_t  enables;
  flag_bus_t  newly_set;
  logic [2:0] set_wins;
  logic       setup_ph;
  logic       access_ph;
  logic       wr_lane0;
  logic       wr_flags2;
  logic       wr_flags3;
  logic       wr_flags4;
  logic       mapped;
  logic [31:0] rd_word;
  logic       core_req;

  // Register write and read strobes, one per register
  logic       wr_enable2;
  logic       wr_enable3;
  logic       wr_enable4;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       rd_status;
  logic [7:0] wr_byte;

  // Status sources, named so each bit's cause is easy to probe
  logic       any_new;
  logic       req_rise;
  logic       any_win;

  // Masks must agree, or a flop would hold what no event explains
  if ((FLAGS2_WR & ~FLAGS2_IMPL) != 8'h00) begin : g_check_flags2
    $error("flags2 write mask exceeds implemented bits");
  end
  if ((FLAGS3_WR & ~FLAGS3_IMPL) != 8'h00) begin : g_check_flags3
    $error("flags3 write mask exceeds implemented bits");
  end
  if ((FLAGS4_WR & ~FLAGS4_IMPL) != 8'h00) begin : g_check_flags4
    $error("flags4 write mask exceeds implemented bits");
  end
  if ((FLAGS4_LVL & ~FLAGS4_IMPL) != 8'h00) begin : g_check_level4
    $error("flags4 level bits exceed implemented bits");
  end
  if ((ENABLE2_IMPL & ~FLAGS2_IMPL) != 8'h00) begin : g_check_enable2
    $error("enable2 covers an unimplemented flag");
  end
  if (CTRL_PERIPHERAL_IRQ_ENABLE_BIT > 7 || ST_W > 8) begin : g_check_fields
    $error("control or status field does not fit the data byte");
  end
  if (((OFS_FLAGS2 | OFS_FLAGS3 | OFS_FLAGS4 | OFS_ENABLE2 | OFS_ENABLE3 | OFS_ENABLE4 |
        OFS_CTRL | OFS_STATUS | OFS_MASK) & 8'h03) != 8'h00) begin : g_check_align
    $error("register offsets must be word aligned");
  end

  // Bundle the bus request
  always_comb begin
    apb.psel    = PSEL_I;
    apb.penable = PENABLE_I;
    apb.pwrite  = PWRITE_I;
    apb.paddr   = PADDR_I;
    apb.pwdata  = PWDATA_I;
    apb.pstrb   = PSTRB_I;
  end

  // Route each event to its flag position
  always_comb begin
    set_bus.f2[7] = OSC_FAIL_I; // R04
    set_bus.f2[6] = TIMER5_GATE_I;
    set_bus.f2[5] = TIMER3_GATE_I;
    set_bus.f2[4] = 1'b0; // R05
    set_bus.f2[3] = SERIAL1_COLLISION_I;
    set_bus.f2[2] = TIMER10_MATCH_I;
    set_bus.f2[1] = TIMER8_MATCH_I;
    set_bus.f2[0] = CAPCMP_I[2];
    // Capture units six to three, then timer events
    set_bus.f3[7] = CAPCMP_I[6]; // R06
    set_bus.f3[6] = CAPCMP_I[5];
    set_bus.f3[5] = CAPCMP_I[4];
    set_bus.f3[4] = CAPCMP_I[3];
    set_bus.f3[3] = TIMER6_MATCH_I;
    set_bus.f3[2] = TIMER5_OVERFLOW_I;
    set_bus.f3[1] = TIMER4_MATCH_I;
    set_bus.f3[0] = TIMER3_OVERFLOW_I;
    // UART levels sit in bits five and four
    set_bus.f4[7] = CAPCMP10_I; // R08
    set_bus.f4[6] = CAPCMP_I[9];
    set_bus.f4[5] = UART2_RECEIVE_I; // R07
    set_bus.f4[4] = UART2_TRANSMIT_I;
    set_bus.f4[3] = CAPCMP_I[8];
    set_bus.f4[2] = CAPCMP_I[7];
    set_bus.f4[1] = SERIAL2_COLLISION_I;
    set_bus.f4[0] = SERIAL2_EVENT_I;
  end

  // Bus phases; writes land only on the completing access edge
  assign setup_ph  = apb.psel & ~apb.penable;
  assign access_ph = apb.psel & apb.penable;
  assign wr_lane0  = access_ph & apb.pwrite & apb.pstrb[0];
  assign wr_flags2 = wr_lane0 & (apb.paddr == OFS_FLAGS2);
  assign wr_flags3 = wr_lane0 & (apb.paddr == OFS_FLAGS3);
  assign wr_flags4 = wr_lane0 & (apb.paddr == OFS_FLAGS4);
  assign wr_enable2 = wr_lane0 & (apb.paddr == OFS_ENABLE2);
  assign wr_enable3 = wr_lane0 & (apb.paddr == OFS_ENABLE3);
  assign wr_enable4 = wr_lane0 & (apb.paddr == OFS_ENABLE4);
  assign wr_ctrl    = wr_lane0 & (apb.paddr == OFS_CTRL);
  assign wr_mask    = wr_lane0 & (apb.paddr == OFS_MASK);
  // Status clears on the completing access edge of a read
  assign rd_status  = access_ph & ~apb.pwrite & (apb.paddr == OFS_STATUS);
  assign wr_byte    = apb.pwdata[7:0];

  // Register two; its masks hold bit four at zero
  request_flag_reg #(
    .IMPL_MASK  (FLAGS2_IMPL),
    .WRITE_MASK (FLAGS2_WR),
    .LEVEL_MASK (FLAGS2_LVL)
  ) u_flags2 (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .en_i        (CLK_EN_I),
    .set_i       (set_bus.f2),
    .wr_i        (wr_flags2),
    .wdata_i     (apb.pwdata[7:0]),
    .flags_o     (flags.f2),
    .newly_set_o (newly_set.f2),
    .set_wins_o  (set_wins[0])
  );

  // Register three; every bit writable
  request_flag_reg #(
    .IMPL_MASK  (FLAGS3_IMPL),
    .WRITE_MASK (FLAGS3_WR),
    .LEVEL_MASK (FLAGS3_LVL)
  ) u_flags3 (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .en_i        (CLK_EN_I),
    .set_i       (set_bus.f3),
    .wr_i        (wr_flags3),
    .wdata_i     (apb.pwdata[7:0]),
    .flags_o     (flags.f3),
    .newly_set_o (newly_set.f3),
    .set_wins_o  (set_wins[1])
  );

  // UART2 bits mirror the UART levels and ignore writes
  request_flag_reg #(
    .IMPL_MASK  (FLAGS4_IMPL),
    .WRITE_MASK (FLAGS4_WR),
    .LEVEL_MASK (FLAGS4_LVL)
  ) u_flags4 (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .en_i        (CLK_EN_I),
    .set_i       (set_bus.f4),
    .wr_i        (wr_flags4),
    .wdata_i     (apb.pwdata[7:0]),
    .flags_o     (flags.f4),
    .newly_set_o (newly_set.f4),
    .set_wins_o  (set_wins[2])
  );

  assign enables.f2 = q.enable2;
  assign enables.f3 = q.enable3;
  assign enables.f4 = q.enable4;

  periph_request_merge u_merge (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RESET_I),
    .en_i      (CLK_EN_I),
    .flags_i   (flags),
    .enables_i (enables),
    .peripheral_irq_enable_i    (q.peripheral_irq_enable),
    .req_o     (core_req)
  );

  // Read mux; unmapped addresses flag an error and read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (apb.paddr == OFS_FLAGS2) begin
      rd_word[7:0] = flags.f2; // R03 R05
    end else if (apb.paddr == OFS_FLAGS3) begin
      rd_word[7:0] = flags.f3;
    end else if (apb.paddr == OFS_FLAGS4) begin
      rd_word[7:0] = flags.f4;
    end else if (apb.paddr == OFS_ENABLE2) begin
      rd_word[7:0] = q.enable2;
    end else if (apb.paddr == OFS_ENABLE3) begin
      rd_word[7:0] = q.enable3;
    end else if (apb.paddr == OFS_ENABLE4) begin
      rd_word[7:0] = q.enable4;
    end else if (apb.paddr == OFS_CTRL) begin
      rd_word[CTRL_PERIPHERAL_IRQ_ENABLE_BIT] = q.peripheral_irq_enable;
    end else if (apb.paddr == OFS_STATUS) begin
      rd_word[ST_W-1:0] = q.status;
    end else if (apb.paddr == OFS_MASK) begin
      rd_word[ST_W-1:0] = q.mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // Next state: register writes, read data capture and sticky status
  always_comb begin
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    st_set = '0;
    st_clr = '0;
    d      = q;
    // Read data is captured in the setup cycle so it comes from a flop
    if (setup_ph) begin
      d.prdata  = apb.pwrite ? 32'h0000_0000 : rd_word;
      d.pslverr = ~mapped;
    end
    // Enable, control and mask writes
    if (wr_enable2) begin
      d.enable2 = wr_byte & ENABLE2_IMPL;
    end
    if (wr_enable3) begin
      d.enable3 = wr_byte;
    end
    if (wr_enable4) begin
      d.enable4 = wr_byte;
    end
    if (wr_ctrl) begin
      d.peripheral_irq_enable = apb.pwdata[CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
    end
    if (wr_mask) begin
      d.mask = apb.pwdata[ST_W-1:0];
    end
    // Clear only what the read reported; a bit set after the setup edge stays
    if (rd_status) begin
      st_clr = q.prdata[ST_W-1:0];
    end
    st_set[ST_FLAG_SET_BIT] = any_new;
    st_set[ST_REQ_RISE_BIT] = req_rise;
    st_set[ST_SET_WINS_BIT] = any_win;
    // An event in the clearing cycle is kept
    d.status   = (q.status & ~st_clr) | st_set;
    d.req_prev = core_req;
  end

  // Status sources
  assign any_new  = |newly_set;
  assign req_rise = core_req & ~q.req_prev;
  assign any_win  = |set_wins;

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      q.enable2  <= ENABLE_RST;
      q.enable3  <= ENABLE_RST;
      q.enable4  <= ENABLE_RST;
      q.peripheral_irq_enable     <= PERIPHERAL_IRQ_ENABLE_RST;
      q.status   <= STATUS_RST;
      q.mask     <= MASK_RST;
      q.prdata   <= 32'h0000_0000;
      q.pslverr  <= 1'b0;
      q.req_prev <= 1'b0;
    end else if (CLK_EN_I) begin
      q <= d;
    end
  end

  // Zero wait states; the clock enable stalls the slave as a whole
  assign PREADY_O         = CLK_EN_I;
  assign PRDATA_O         = q.prdata;
  assign PSLVERR_O        = q.pslverr & access_ph;
  // Request lags the flag by one registered cycle
  assign PERIPH_IRQ_REQ_O = core_req; // R10 R11
  assign IRQ_O            = |(q.status & q.mask);

endmodule
`default_nettype wire

// >>> bench/flag_bank_checker.sv
// Port-level assertions for the peripheral request flag bank.
// Assumes one clock domain and an APB master on the register port.
`timescale 1ns/1ps
`default_nettype none
module flag_bank_checker
  import flag_bank_pkg::*;
(
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic        CLK_EN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        OSC_FAIL_I,
  input wire logic [9:2]  CAPCMP_I,
  input wire logic        PERIPH_IRQ_REQ_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  logic acc;
  logic wr;
  logic ev;
  logic peripheral_irq_enable_q;
  logic mask_q;
  logic setup_q;
  // Completed transfer and a sample of event inputs
  assign acc = PSEL_I && PENABLE_I && PREADY_O;
  assign wr  = acc && PWRITE_I && PSTRB_I[0];
  assign ev  = OSC_FAIL_I || (|CAPCMP_I);

  // Shadow of the enable and mask bit zero, tracked from bus writes
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      peripheral_irq_enable_q  <= 1'b0;
      mask_q  <= 1'b0;
      setup_q <= 1'b0;
    end else begin
      setup_q <= PSEL_I && !PENABLE_I;
      if (wr && PADDR_I == OFS_CTRL) begin
        peripheral_irq_enable_q <= PWDATA_I[0];
      end
      if (wr && PADDR_I == OFS_MASK) begin
        mask_q <= PWDATA_I[0];
      end
    end
  end

  reserved_bit_a: assert property (
    acc && !PWRITE_I && PADDR_I == OFS_FLAGS2 |-> PRDATA_O[4] == 1'b0)
    else $error("reserved flag bit read as one");
  upper_bits_a: assert property (
    acc && !PWRITE_I |-> PRDATA_O[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  periph_gate_a: assert property (
    !$past(peripheral_irq_enable_q) |-> !PERIPH_IRQ_REQ_O)
    else $error("core request without peripheral enable");
  event_irq_a: assert property (
    ev && mask_q |=> ##[0:1] IRQ_O)
    else $error("unmasked event gave no interrupt");
  err_access_a: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
    else $error("error outside access phase");
  unmapped_err_a: assert property (
    acc && (PADDR_I > OFS_MASK || PADDR_I[1:0] != 2'b00) |-> PSLVERR_O)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    acc && PADDR_I <= OFS_MASK && PADDR_I[1:0] == 2'b00 |-> !PSLVERR_O)
    else $error("mapped access refused");
  ready_follow_a: assert property (PREADY_O == CLK_EN_I)
    else $error("ready does not follow clock enable");
  read_hold_a: assert property (!setup_q |-> $stable(PRDATA_O))
    else $error("read data moved outside setup");
  reset_clear_a: assert property (
    $fell(RESET_I) |-> !PERIPH_IRQ_REQ_O && !IRQ_O && PRDATA_O == 32'h00000000)
    else $error("outputs not clear after reset");

  // Main scenarios reached
  err_seen_c: cover property (acc && PSLVERR_O);
  req_rise_c: cover property ($rose(PERIPH_IRQ_REQ_O));
  irq_rise_c: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

// >>> bench/periph_event_model.sv
// Peripheral side model: event pulses and second UART status levels.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module periph_event_model
  import flag_bank_pkg::*;
(
  input  wire logic       clk_i,
  output var  flag_bus_t  ev_o,
  output logic            rx_o,
  output logic            tx_o
);
  // Quiet lines from time zero
  initial begin
    ev_o = '0;
    rx_o = 1'b0;
    tx_o = 1'b0;
  end

  // One-cycle pulse after d extra edges, so it can land on a bus edge
  task automatic fire(input flag_bus_t v, input int d);
    repeat (d + 1) @(posedge clk_i);
    ev_o <= v;
    @(posedge clk_i);
    ev_o <= '0;
  endtask

  // UART status is a held level, not a pulse
  task automatic uart(input logic rx, input logic tx);
    @(posedge clk_i);
    rx_o <= rx;
    tx_o <= tx;
  endtask
endmodule
`default_nettype wire

// >>> bench/peripheral_irq_flag_bank_tb.sv
// Self-checking bench for the peripheral request flag bank.
// Assumes the event model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_bank_tb
  import flag_bank_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        req;
  logic        irq;
  logic        rx;
  logic        tx;
  flag_bus_t   ev;
  flag_bus_t   v;
  logic [7:0]  a;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  periph_event_model pm (.clk_i(clk), .ev_o(ev), .rx_o(rx), .tx_o(tx));

  peripheral_irq_flag_bank peripheral_irq_flag_bank_inst (
    .SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .OSC_FAIL_I(ev.f2[7]), .TIMER5_GATE_I(ev.f2[6]), .TIMER3_GATE_I(ev.f2[5]),
    .SERIAL1_COLLISION_I(ev.f2[3]), .TIMER10_MATCH_I(ev.f2[2]),
    .TIMER8_MATCH_I(ev.f2[1]),
    .CAPCMP_I({ev.f4[6], ev.f4[3], ev.f4[2], ev.f3[7:4], ev.f2[0]}),
    .TIMER6_MATCH_I(ev.f3[3]), .TIMER5_OVERFLOW_I(ev.f3[2]),
    .TIMER4_MATCH_I(ev.f3[1]), .TIMER3_OVERFLOW_I(ev.f3[0]),
    .CAPCMP10_I(ev.f4[7]), .UART2_RECEIVE_I(rx), .UART2_TRANSMIT_I(tx),
    .SERIAL2_COLLISION_I(ev.f4[1]), .SERIAL2_EVENT_I(ev.f4[0]),
    .PERIPH_IRQ_REQ_O(req), .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short; the whole run needs about 330 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // One APB transfer; only the bench timeout ends a wait for ready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h00000000);
    chk(what, exp, rd);
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdchk("flags2", OFS_FLAGS2, 32'h00000000);
    rdchk("flags3", OFS_FLAGS3, 32'h00000000);
    rdchk("flags4", OFS_FLAGS4, 32'h00000000);
    $display("reset test done");
    // Each event alone, every enable off, then cleared by software
    for (int i = 0; i < 24; i++) begin
      if (i != 4 && i != 20 && i != 21) begin
        v = flag_bus_t'(24'h000001 << i);
        a = 8'(4 * (i / 8));
        pm.fire(v, 0);
        rdchk("one flag", a, 32'(8'h01 << (i % 8)));
        apb(1'b1, a, 32'h00000000);
        rdchk("cleared flag", a, 32'h00000000);
      end
    end
    $display("event map test done");
    apb(1'b1, OFS_FLAGS2, 32'h000000FF);
    rdchk("flags2 all", OFS_FLAGS2, 32'h000000EF);
    apb(1'b1, OFS_FLAGS4, 32'h000000FF);
    rdchk("flags4 all", OFS_FLAGS4, 32'h000000CF);
    pm.uart(1'b1, 1'b1);
    rdchk("uart up", OFS_FLAGS4, 32'h000000FF);
    apb(1'b1, OFS_FLAGS4, 32'h00000000);
    rdchk("uart read only", OFS_FLAGS4, 32'h00000030);
    pm.uart(1'b0, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("flags2 reset", OFS_FLAGS2, 32'h00000000);
    $display("access test done");
    // Flags are clear before the enable is set
    apb(1'b1, OFS_ENABLE3, 32'h00000001);
    pm.fire(24'h000100, 0);
    repeat (3) @(posedge clk);
    chk("req gated", 32'h0, 32'(req));
    apb(1'b1, OFS_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("req on", 32'h1, 32'(req));
    rdchk("status req", OFS_STATUS, 32'h00000003);
    apb(1'b1, OFS_FLAGS3, 32'h00000000);
    repeat (2) @(posedge clk);
    chk("req off", 32'h0, 32'(req));
    $display("request test done");
    apb(1'b1, OFS_MASK, 32'h00000001);
    pm.fire(24'h000080, 0);
    repeat (2) @(posedge clk);
    chk("irq up", 32'h1, 32'(irq));
    rdchk("status set", OFS_STATUS, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, OFS_MASK, 32'h00000000);
    pm.fire(24'h000080, 0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    // Hardware set lands on the same edge as a software clear
    fork
      apb(1'b1, OFS_FLAGS2, 32'h00000000);
      pm.fire(24'h000001, 1);
    join
    rdchk("set wins", OFS_FLAGS2, 32'h00000001);
    rdchk("status wins", OFS_STATUS, 32'h00000005);
    $display("interrupt test done");
    apb(1'b0, 8'h24, 32'h00000000);
    chk("unmapped read err", 32'h1, 32'(err));
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 8'h24, 32'h000000FF);
    chk("unmapped write err", 32'h1, 32'(err));
    $display("refusal test done");
    wrap_up();
  end
endmodule

bind peripheral_irq_flag_bank flag_bank_checker flag_bank_checker_inst (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .CLK_EN_I(CLK_EN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .OSC_FAIL_I(OSC_FAIL_I), .CAPCMP_I(CAPCMP_I),
  .PERIPH_IRQ_REQ_O(PERIPH_IRQ_REQ_O), .IRQ_O(IRQ_O));
`default_nettype wire
